// *** src/gpcde_pkg.sv ***
`default_nettype none
package gpcde_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned GPCDE_ADDR_W = 12;
  localparam int unsigned GPCDE_DATA_W = 32;
  localparam int unsigned GPCDE_IDX_W  = 10;
  localparam int unsigned GPCDE_C_W    = 7;
  localparam int unsigned GPCDE_D_W    = 8;
  localparam int unsigned GPCDE_E_W    = 6;
  localparam int unsigned GPCDE_REG_W  = 8;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [9:0] GPCDE_IDX_D_DATA  = 10'h003;
  localparam logic [9:0] GPCDE_IDX_D_DIR   = 10'h007;
  localparam logic [9:0] GPCDE_IDX_E_DATA  = 10'h008;
  localparam logic [9:0] GPCDE_IDX_E_DIR   = 10'h00c;
  localparam logic [9:0] GPCDE_IDX_C_PUE   = 10'h00d;
  localparam logic [9:0] GPCDE_IDX_D_PUE   = 10'h00e;
  localparam logic [9:0] GPCDE_IDX_ALT_CTL = 10'h010;
  localparam logic [9:0] GPCDE_IDX_TIM_ELS = 10'h011;
  localparam logic [1:0] GPCDE_WORD_ALIGN  = 2'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GPCDE_D_DIR_RST   = 8'h00;
  localparam logic [5:0] GPCDE_E_DIR_RST   = 6'h00;
  localparam logic [6:0] GPCDE_C_PUE_RST   = 7'h00;
  localparam logic [7:0] GPCDE_D_PUE_RST   = 8'h00;
  localparam logic [2:0] GPCDE_ALT_CTL_RST = 3'h0;
  localparam logic [7:0] GPCDE_TIM_ELS_RST = 8'h00;
  localparam logic [7:0] GPCDE_OE_N_IDLE   = 8'hff;
  localparam logic [7:0] GPCDE_ZERO8       = 8'h00;
  localparam logic [23:0] GPCDE_RD_PAD     = 24'h000000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned GPCDE_CTL_SPI_EN  = 0;
  localparam int unsigned GPCDE_CTL_SPI_MST = 1;
  localparam int unsigned GPCDE_CTL_SCI_EN  = 2;
  localparam int unsigned GPCDE_ELS_T1C0    = 0;
  localparam int unsigned GPCDE_ELS_T1C1    = 2;
  localparam int unsigned GPCDE_ELS_T2C0    = 4;
  localparam int unsigned GPCDE_ELS_T2C1    = 6;

endpackage : gpcde_pkg
`default_nettype wire

// *** src/gpcde_pins_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface gpcde_pins_if;
  logic [7:0] d_latch;
  logic [7:0] d_dir;
  logic [7:0] d_pue;
  logic [7:0] d_take;
  logic [7:0] d_alt_out;
  logic [7:0] d_alt_oe_n;
  logic [7:0] d_out;
  logic [7:0] d_oe_n;
  logic [7:0] d_pull;
  logic [5:0] e_latch;
  logic [5:0] e_dir;
  logic [5:0] e_take;
  logic [5:0] e_alt_out;
  logic [5:0] e_alt_oe_n;
  logic [5:0] e_out;
  logic [5:0] e_oe_n;

  modport ctl (output d_latch, d_dir, d_pue, d_take, d_alt_out, d_alt_oe_n,
               output e_latch, e_dir, e_take, e_alt_out, e_alt_oe_n,
               input  d_out, d_oe_n, d_pull, e_out, e_oe_n);
  modport mux (input  d_latch, d_dir, d_pue, d_take, d_alt_out, d_alt_oe_n,
               input  e_latch, e_dir, e_take, e_alt_out, e_alt_oe_n,
               output d_out, d_oe_n, d_pull, e_out, e_oe_n);
endinterface : gpcde_pins_if
`default_nettype wire

// *** src/gpcde_pin_mux.sv ***
`timescale 1ns/1ns
`default_nettype none
module gpcde_pin_mux
  import gpcde_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  gpcde_pins_if.mux p
);

  logic [7:0] d_out_reg,  d_out_next;
  logic [7:0] d_oe_n_reg, d_oe_n_next;
  logic [7:0] d_pull_reg, d_pull_next;
  logic [5:0] e_out_reg,  e_out_next;
  logic [5:0] e_oe_n_reg, e_oe_n_next;

  // Taken pins follow the peripheral; others follow direction
  function automatic logic [7:0] pin_oe_n(input logic [7:0] take, input logic [7:0] alt_oe_n,
                                          input logic [7:0] dir);
    pin_oe_n = (take & alt_oe_n) | (~take & ~dir);
  endfunction : pin_oe_n

  // Pins neither taken nor set to output show zero so the latch never leaks an unknown
  function automatic logic [7:0] pin_val(input logic [7:0] take, input logic [7:0] alt_out,
                                         input logic [7:0] dir, input logic [7:0] latch);
    pin_val = (take & alt_out) | (~take & dir & latch);
  endfunction : pin_val

  always_comb begin
    d_oe_n_next = pin_oe_n(p.d_take, p.d_alt_oe_n, p.d_dir);
    d_out_next  = pin_val(p.d_take, p.d_alt_out, p.d_dir, p.d_latch);
    d_pull_next = p.d_pue & d_oe_n_next;
    e_oe_n_next = 6'(pin_oe_n({2'h0, p.e_take}, {2'h0, p.e_alt_oe_n}, {2'h0, p.e_dir}));
    e_out_next  = 6'(pin_val({2'h0, p.e_take}, {2'h0, p.e_alt_out}, {2'h0, p.e_dir}, {2'h0, p.e_latch}));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_out_reg  <= GPCDE_ZERO8;
      d_oe_n_reg <= GPCDE_OE_N_IDLE;
      d_pull_reg <= GPCDE_ZERO8;
      e_out_reg  <= GPCDE_ZERO8[5:0];
      e_oe_n_reg <= GPCDE_OE_N_IDLE[5:0];
    end else begin
      d_out_reg  <= d_out_next;
      d_oe_n_reg <= d_oe_n_next;
      d_pull_reg <= d_pull_next;
      e_out_reg  <= e_out_next;
      e_oe_n_reg <= e_oe_n_next;
    end
  end

  assign p.d_out  = d_out_reg;
  assign p.d_oe_n = d_oe_n_reg;
  assign p.d_pull = d_pull_reg;
  assign p.e_out  = e_out_reg;
  assign p.e_oe_n = e_oe_n_reg;

endmodule : gpcde_pin_mux
`default_nettype wire

// *** src/gpcde_ports.sv ***
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Port C pull-up only on input pins
// - Port D eight-bit latch, reset keeps it
// - D7/D6 timer one channels via select bits
// - D5/D4 timer two channels via select bits
// - D3..D1 SPI pins, GPIO when SPI off
// - D0 slave select unless off or master
// - SPI pins: direction only picks read source
// - D direction 1 drives; reset clears
// - D read: latch if output, else pin
// - Latch writes with pstrb[0] set always land, input unaffected
// - Port D pull-up only on input pins
// - Port E six-bit latch, reset keeps it
// - E1/E0 serial pins, GPIO when off
// - Serial pins: direction only picks read source
// - E direction 1 drives; reset clears
// - E read: latch if output, else pin
module gpcde_ports
  import gpcde_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  port_c_direction,
  output logic      [6:0]  pin_c_pullup,
  input  wire logic [7:0]  pin_d_in,
  output logic      [7:0]  pin_d_out,
  output logic      [7:0]  pin_d_oe_n,
  output logic      [7:0]  pin_d_pullup,
  input  wire logic [5:0]  pin_e_in,
  output logic      [5:0]  pin_e_out,
  output logic      [5:0]  pin_e_oe_n,
  input  wire logic [7:0]  alt_d_out,
  input  wire logic [7:0]  alt_d_oe_n,
  input  wire logic [1:0]  alt_e_out,
  input  wire logic [1:0]  alt_e_oe_n,
  output logic             spi_enable_bit,
  output logic             spi_master_bit,
  output logic             serial_if_enable_bit,
  output logic      [7:0]  timer_edge_level_sel
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic idx_hit(input logic [11:0] addr, input logic [9:0] idx);
    idx_hit = (addr[11:2] == idx) && (addr[1:0] == GPCDE_WORD_ALIGN);
  endfunction : idx_hit

  // Direction picks latch or pin even for pins a peripheral owns
  function automatic logic [7:0] rd_mix(input logic [7:0] dir, input logic [7:0] latch,
                                        input logic [7:0] pin);
    rd_mix = (dir & latch) | (~dir & pin);
  endfunction : rd_mix

  function automatic logic els_on(input logic [7:0] els, input int unsigned pos);
    els_on = |els[pos +: 2];
  endfunction : els_on

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  d_latch_reg,  d_latch_next;
  logic [5:0]  e_latch_reg,  e_latch_next;
  logic [7:0]  d_dir_reg,    d_dir_next;
  logic [5:0]  e_dir_reg,    e_dir_next;
  logic [6:0]  c_pue_reg,    c_pue_next;
  logic [7:0]  d_pue_reg,    d_pue_next;
  logic [2:0]  alt_ctl_reg,  alt_ctl_next;
  logic [7:0]  tim_els_reg,  tim_els_next;
  logic [31:0] prdata_reg,   prdata_next;
  logic        pslverr_reg,  pslverr_next;
  logic [6:0]  c_pull_reg,   c_pull_next;

  logic       setup_ph;
  logic       wr_acc;
  logic       addr_ok;
  logic [7:0] rd_byte;
  logic [7:0] d_take;
  logic [5:0] e_take;

  gpcde_pins_if pins ();

  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pwrite && pstrb[0];

  always_comb begin
    addr_ok = 1'b1;
    rd_byte = GPCDE_ZERO8;
    if (idx_hit(paddr, GPCDE_IDX_D_DATA)) begin
      rd_byte = rd_mix(d_dir_reg, d_latch_reg, pin_d_in);
    end else if (idx_hit(paddr, GPCDE_IDX_D_DIR)) begin
      rd_byte = d_dir_reg;
    end else if (idx_hit(paddr, GPCDE_IDX_E_DATA)) begin
      rd_byte = {2'h0, 6'(rd_mix({2'h0, e_dir_reg}, {2'h0, e_latch_reg}, {2'h0, pin_e_in}))};
    end else if (idx_hit(paddr, GPCDE_IDX_E_DIR)) begin
      rd_byte = {2'h0, e_dir_reg};
    end else if (idx_hit(paddr, GPCDE_IDX_C_PUE)) begin
      rd_byte = {1'h0, c_pue_reg};
    end else if (idx_hit(paddr, GPCDE_IDX_D_PUE)) begin
      rd_byte = d_pue_reg;
    end else if (idx_hit(paddr, GPCDE_IDX_ALT_CTL)) begin
      rd_byte = {5'h00, alt_ctl_reg};
    end else if (idx_hit(paddr, GPCDE_IDX_TIM_ELS)) begin
      rd_byte = tim_els_reg;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Read data and error are taken in setup, shown in the access phase
  always_comb begin
    prdata_next  = prdata_reg;
    pslverr_next = pslverr_reg;
    if (setup_ph) begin
      prdata_next  = pwrite ? {GPCDE_RD_PAD, GPCDE_ZERO8} : {GPCDE_RD_PAD, rd_byte};
      pslverr_next = !addr_ok;
    end
  end

  always_comb begin
    d_latch_next = d_latch_reg;
    e_latch_next = e_latch_reg;
    d_dir_next   = d_dir_reg;
    e_dir_next   = e_dir_reg;
    c_pue_next   = c_pue_reg;
    d_pue_next   = d_pue_reg;
    alt_ctl_next = alt_ctl_reg;
    tim_els_next = tim_els_reg;
    if (wr_acc) begin
      if (idx_hit(paddr, GPCDE_IDX_D_DATA)) begin
        d_latch_next = pwdata[7:0];
      end else if (idx_hit(paddr, GPCDE_IDX_D_DIR)) begin
        d_dir_next = pwdata[7:0];
      end else if (idx_hit(paddr, GPCDE_IDX_E_DATA)) begin
        e_latch_next = pwdata[5:0];
      end else if (idx_hit(paddr, GPCDE_IDX_E_DIR)) begin
        e_dir_next = pwdata[5:0];
      end else if (idx_hit(paddr, GPCDE_IDX_C_PUE)) begin
        c_pue_next = pwdata[6:0];
      end else if (idx_hit(paddr, GPCDE_IDX_D_PUE)) begin
        d_pue_next = pwdata[7:0];
      end else if (idx_hit(paddr, GPCDE_IDX_ALT_CTL)) begin
        alt_ctl_next = pwdata[2:0];
      end else if (idx_hit(paddr, GPCDE_IDX_TIM_ELS)) begin
        tim_els_next = pwdata[7:0];
      end
    end
  end

  // Pull-up drops one clock after the direction bit asks for output
  always_comb begin
    c_pull_next = c_pue_reg & ~port_c_direction;
  end

  // Data latches keep their contents across reset
  always_ff @(posedge pclk) begin
    d_latch_reg <= d_latch_next;
    e_latch_reg <= e_latch_next;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_dir_reg   <= GPCDE_D_DIR_RST;
      e_dir_reg   <= GPCDE_E_DIR_RST;
      c_pue_reg   <= GPCDE_C_PUE_RST;
      d_pue_reg   <= GPCDE_D_PUE_RST;
      alt_ctl_reg <= GPCDE_ALT_CTL_RST;
      tim_els_reg <= GPCDE_TIM_ELS_RST;
      prdata_reg  <= {GPCDE_RD_PAD, GPCDE_ZERO8};
      pslverr_reg <= 1'b0;
      c_pull_reg  <= GPCDE_C_PUE_RST;
    end else begin
      d_dir_reg   <= d_dir_next;
      e_dir_reg   <= e_dir_next;
      c_pue_reg   <= c_pue_next;
      d_pue_reg   <= d_pue_next;
      alt_ctl_reg <= alt_ctl_next;
      tim_els_reg <= tim_els_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
      c_pull_reg  <= c_pull_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin ownership
  // ----------------------------------------------------------------
  always_comb begin
    d_take    = GPCDE_ZERO8;
    d_take[7] = els_on(tim_els_reg, GPCDE_ELS_T1C1);
    d_take[6] = els_on(tim_els_reg, GPCDE_ELS_T1C0);
    d_take[5] = els_on(tim_els_reg, GPCDE_ELS_T2C1);
    d_take[4] = els_on(tim_els_reg, GPCDE_ELS_T2C0);
    d_take[3] = alt_ctl_reg[GPCDE_CTL_SPI_EN];
    d_take[2] = alt_ctl_reg[GPCDE_CTL_SPI_EN];
    d_take[1] = alt_ctl_reg[GPCDE_CTL_SPI_EN];
    d_take[0] = alt_ctl_reg[GPCDE_CTL_SPI_EN] && !alt_ctl_reg[GPCDE_CTL_SPI_MST];
    e_take    = {4'h0, {2{alt_ctl_reg[GPCDE_CTL_SCI_EN]}}};
  end

  assign pins.d_latch    = d_latch_reg;
  assign pins.d_dir      = d_dir_reg;
  assign pins.d_pue      = d_pue_reg;
  assign pins.d_take     = d_take;
  assign pins.d_alt_out  = alt_d_out;
  assign pins.d_alt_oe_n = alt_d_oe_n;
  assign pins.e_latch    = e_latch_reg;
  assign pins.e_dir      = e_dir_reg;
  assign pins.e_take     = e_take;
  assign pins.e_alt_out  = {4'h0, alt_e_out};
  assign pins.e_alt_oe_n = {4'hf, alt_e_oe_n};

  gpcde_pin_mux u_mux (
    .pclk    (pclk),
    .presetn (presetn),
    .p       (pins.mux)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero wait states keep the bus simple; every access ends at once
  assign pready               = 1'b1;
  assign prdata               = prdata_reg;
  assign pslverr              = pslverr_reg && psel && penable;
  assign pin_c_pullup         = c_pull_reg;
  assign pin_d_out            = pins.d_out;
  assign pin_d_oe_n           = pins.d_oe_n;
  assign pin_d_pullup         = pins.d_pull;
  assign pin_e_out            = pins.e_out;
  assign pin_e_oe_n           = pins.e_oe_n;
  assign spi_enable_bit       = alt_ctl_reg[GPCDE_CTL_SPI_EN];
  assign spi_master_bit       = alt_ctl_reg[GPCDE_CTL_SPI_MST];
  assign serial_if_enable_bit = alt_ctl_reg[GPCDE_CTL_SCI_EN];
  assign timer_edge_level_sel = tim_els_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr_d_data;
    psel && penable && pwrite && pstrb[0] && idx_hit(paddr, GPCDE_IDX_D_DATA);
  endsequence

  sequence s_rd_setup(logic [9:0] idx);
    psel && !penable && !pwrite && idx_hit(paddr, idx);
  endsequence

  sequence s_wr_e_data;
    psel && penable && pwrite && pstrb[0] && idx_hit(paddr, GPCDE_IDX_E_DATA);
  endsequence

  property p_c_pull;
    ##1 pin_c_pullup == $past(c_pue_reg & ~port_c_direction);
  endproperty
  a_c_pull: assert property (p_c_pull) else $error("port C pull-up wrong");

  property p_d_latch_wr;
    s_wr_d_data |=> d_latch_reg == $past(pwdata[7:0]);
  endproperty
  a_d_latch_wr: assert property (p_d_latch_wr) else $error("port D latch not written");

  property p_t1_pins;
    (d_take[7] && d_take[6]) |=> pin_d_oe_n[7:6] == $past(alt_d_oe_n[7:6]) && pin_d_out[7:6] == $past(alt_d_out[7:6]);
  endproperty
  a_t1_pins: assert property (p_t1_pins) else $error("timer one pins not handed over");

  property p_t2_pins;
    (tim_els_reg[GPCDE_ELS_T2C0 +: 2] != 2'h0) |=> pin_d_oe_n[4] == $past(alt_d_oe_n[4]);
  endproperty
  a_t2_pins: assert property (p_t2_pins) else $error("timer two pin not handed over");

  property p_spi_off;
    !spi_enable_bit && (tim_els_reg == GPCDE_ZERO8) |=> pin_d_oe_n == ~$past(d_dir_reg);
  endproperty
  a_spi_off: assert property (p_spi_off) else $error("GPIO direction ignored");

  property p_ss_pin;
    spi_enable_bit && !spi_master_bit |=> pin_d_oe_n[0] == $past(alt_d_oe_n[0]);
  endproperty
  a_ss_pin: assert property (p_ss_pin) else $error("slave select follows direction");

  property p_d_read;
    s_rd_setup(GPCDE_IDX_D_DATA) ##1 (psel && penable)
      |-> prdata[7:0] == $past(rd_mix(d_dir_reg, d_latch_reg, pin_d_in)) && prdata[31:8] == 24'h0;
  endproperty
  a_d_read: assert property (p_d_read) else $error("port D read data wrong");

  property p_d_pull;
    ##1 pin_d_pullup == ($past(d_pue_reg) & pin_d_oe_n);
  endproperty
  a_d_pull: assert property (p_d_pull) else $error("port D pull-up on driven pin");

  property p_sci_pins;
    serial_if_enable_bit |=> pin_e_oe_n[1:0] == $past(alt_e_oe_n) && pin_e_out[1:0] == $past(alt_e_out);
  endproperty
  a_sci_pins: assert property (p_sci_pins) else $error("serial pins not handed over");

  property p_e_read;
    s_rd_setup(GPCDE_IDX_E_DATA) ##1 (psel && penable)
      |-> prdata[5:0] == $past((e_dir_reg & e_latch_reg) | (~e_dir_reg & pin_e_in)) && prdata[31:6] == 26'h0;
  endproperty
  a_e_read: assert property (p_e_read) else $error("port E read data wrong");

  property p_e_gpio;
    !serial_if_enable_bit |=> pin_e_oe_n == ~$past(e_dir_reg) && pin_e_out == $past(e_dir_reg & e_latch_reg);
  endproperty
  a_e_gpio: assert property (p_e_gpio) else $error("port E GPIO pins wrong");

  property p_e_latch_wr;
    s_wr_e_data |=> e_latch_reg == $past(pwdata[5:0]);
  endproperty
  a_e_latch_wr: assert property (p_e_latch_wr) else $error("port E latch not written");

  property p_spi_pins;
    spi_enable_bit |=> pin_d_out[3:1] == $past(alt_d_out[3:1]) && pin_d_oe_n[3:1] == $past(alt_d_oe_n[3:1]);
  endproperty
  a_spi_pins: assert property (p_spi_pins) else $error("SPI pins not handed over");

  property p_ss_gpio;
    spi_enable_bit && spi_master_bit
      |=> pin_d_oe_n[0] == ~$past(d_dir_reg[0]) && pin_d_out[0] == $past(d_dir_reg[0] & d_latch_reg[0]);
  endproperty
  a_ss_gpio: assert property (p_ss_gpio) else $error("slave select pin not GPIO in master mode");

  property p_rd_upper;
    psel && penable |-> prdata[31:8] == 24'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("unimplemented read bits not zero");

endmodule : gpcde_ports
`default_nettype wire

// *** sim/test_gpio_ports_c_d_e.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_gpio_ports_c_d_e
  import gpcde_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and register map
  // ----------------------------------------------------------------
  localparam logic [11:0] A_DL = {GPCDE_IDX_D_DATA, GPCDE_WORD_ALIGN};
  localparam logic [11:0] A_DD = {GPCDE_IDX_D_DIR, GPCDE_WORD_ALIGN};
  localparam logic [11:0] A_EL = {GPCDE_IDX_E_DATA, GPCDE_WORD_ALIGN};
  localparam logic [11:0] A_ED = {GPCDE_IDX_E_DIR, GPCDE_WORD_ALIGN};
  localparam logic [11:0] A_CP = {GPCDE_IDX_C_PUE, GPCDE_WORD_ALIGN};
  localparam logic [11:0] A_DP = {GPCDE_IDX_D_PUE, GPCDE_WORD_ALIGN};
  localparam logic [11:0] A_CT = {GPCDE_IDX_ALT_CTL, GPCDE_WORD_ALIGN};
  localparam logic [11:0] A_TE = {GPCDE_IDX_TIM_ELS, GPCDE_WORD_ALIGN};

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [6:0]  c_dir, c_pu;
  logic [7:0]  d_in, d_out, d_oe_n, d_pu, ad_out, ad_oe_n, els_o;
  logic [5:0]  e_in, e_out, e_oe_n;
  logic [1:0]  ae_out, ae_oe_n;
  logic        spi_en, spi_ms, sci_en;
  logic [7:0]  m_dl, m_dd, m_dp, m_els;
  logic [5:0]  m_el, m_ed;
  logic [6:0]  m_cp;
  logic [2:0]  m_ctl;
  int          err_total, total_checks;

  gpcde_ports i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_c_direction(c_dir), .pin_c_pullup(c_pu), .pin_d_in(d_in),
    .pin_d_out(d_out), .pin_d_oe_n(d_oe_n), .pin_d_pullup(d_pu), .pin_e_in(e_in),
    .pin_e_out(e_out), .pin_e_oe_n(e_oe_n), .alt_d_out(ad_out), .alt_d_oe_n(ad_oe_n),
    .alt_e_out(ae_out), .alt_e_oe_n(ae_oe_n), .spi_enable_bit(spi_en),
    .spi_master_bit(spi_ms), .serial_if_enable_bit(sci_en), .timer_edge_level_sel(els_o)
  );

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] st, output logic [31:0] rd, output logic er);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait for the answer ends on the first edge that sees pready high
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never re-drives psel in this step
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, 4'hf, rd, er);
  endtask : wr

  task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, 4'hf, rd, er);
    `CHK(nm, {24'h000000, e}, rd)
    `CHK("rd_err", 1'b0, er)
  endtask : rchk

  function automatic logic [7:0] own_d();
    return {|m_els[3:2], |m_els[1:0], |m_els[7:6], |m_els[5:4], {3{m_ctl[0]}}, m_ctl[0] & ~m_ctl[1]};
  endfunction : own_d

  task automatic check_pins();
    logic [7:0] od, eo;
    logic [5:0] oe, ee;
    // Pin outputs lag their cause by one registered stage
    repeat (2) @(posedge pclk);
    od = own_d();
    oe = {4'h0, {2{m_ctl[2]}}};
    eo = (od & ad_oe_n) | (~od & ~m_dd);
    ee = (oe & {4'hf, ae_oe_n}) | (~oe & ~m_ed);
    `CHK("d_oe_n", eo, d_oe_n)
    `CHK("d_out", (od & ad_out) | (~od & m_dl & m_dd), d_out)
    `CHK("d_pull", m_dp & eo, d_pu)
    `CHK("e_oe_n", ee, e_oe_n)
    `CHK("e_out", (oe & {4'h0, ae_out}) | (~oe & m_el & m_ed), e_out)
    `CHK("c_pull", m_cp & ~c_dir, c_pu)
    `CHK("cfg", {m_ctl, m_els}, {sci_en, spi_ms, spi_en, els_o})
  endtask : check_pins

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic        er;
    err_total = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    c_dir = 7'h00;
    d_in = 8'h00;
    e_in = 6'h00;
    ad_out = 8'h00;
    ad_oe_n = 8'hff;
    ae_out = 2'h0;
    ae_oe_n = 2'h3;
    {m_dd, m_dp, m_els, m_ed, m_cp, m_ctl} = '0;
    void'($urandom(27811));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("d_dir_rst", A_DD, 8'h00);
    rchk("e_dir_rst", A_ED, 8'h00);
    for (int i = 0; i < 40; i++) begin
      m_dl  = 8'($urandom);
      m_dd  = 8'($urandom);
      m_dp  = 8'($urandom);
      m_el  = 6'($urandom);
      m_ed  = 6'($urandom);
      m_cp  = 7'($urandom);
      m_ctl = (i < 8) ? i[2:0] : 3'($urandom);
      // Early passes walk every nonzero select code through every timer field
      m_els = (i < 12) ? 8'((i % 3 + 1) << (2 * (i / 3))) : 8'($urandom);
      d_in    <= 8'($urandom);
      e_in    <= 6'($urandom);
      c_dir   <= 7'($urandom);
      ad_out  <= 8'($urandom);
      ad_oe_n <= 8'($urandom);
      ae_out  <= 2'($urandom);
      ae_oe_n <= 2'($urandom);
      wr(A_DL, {24'h0, m_dl});
      wr(A_EL, {24'h0, 2'($urandom), m_el});
      wr(A_DD, {24'h0, m_dd});
      wr(A_ED, {26'h0, 2'($urandom), m_ed});
      wr(A_CP, {24'h0, 1'($urandom), m_cp});
      wr(A_DP, {24'h0, m_dp});
      wr(A_CT, {29'h0, m_ctl});
      wr(A_TE, {24'h0, m_els});
      check_pins();
      rchk("d_data", A_DL, (m_dd & m_dl) | (~m_dd & d_in));
      rchk("e_data", A_EL, {2'b00, (m_ed & m_el) | (~m_ed & e_in)});
      rchk("d_dir", A_DD, m_dd);
      rchk("e_dir", A_ED, {2'b00, m_ed});
      rchk("c_pue", A_CP, {1'b0, m_cp});
      rchk("d_pue", A_DP, m_dp);
    end
    apb(1'b1, A_DD, 32'h0000_00a5, 4'he, rd, er);
    rchk("strb_off", A_DD, m_dd);
    apb(1'b0, 12'h3fc, 32'h0, 4'hf, rd, er);
    `CHK("unmapped_err", 1'b1, er)
    `CHK("unmapped_rd", 32'h0, rd)
    apb(1'b1, 12'h00d, 32'h0000_00ff, 4'hf, rd, er);
    `CHK("misalign_err", 1'b1, er)
    // Mid-run reset: configuration clears, latches must survive
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    {m_dd, m_dp, m_els, m_ed, m_cp, m_ctl} = '0;
    check_pins();
    rchk("d_dir_rst2", A_DD, 8'h00);
    m_dd = 8'hff;
    m_ed = 6'h3f;
    wr(A_DD, 32'h0000_00ff);
    wr(A_ED, 32'h0000_003f);
    rchk("d_keep", A_DL, m_dl);
    rchk("e_keep", A_EL, {2'b00, m_el});
    check_pins();
    end_sim();
  end

  initial begin
    #(300000);
    err_total++;
    end_sim();
  end
endmodule : test_gpio_ports_c_d_e
`default_nettype wire
